// >>> common/ifpr_pkg.sv
// constants, register map and types for the infrared frame parameter block
// Operation
// - 4M mode preamble count from bits 7:6: 00=16, 01=8, 10=4, 11=32.
// - bits 5:4 pick transmit trigger in empty entries; column set by size.
// - 1M mode start flag count equals the value in bits 3:0.
// - read-only eight-bit count of bytes held in receive FIFO, zero at reset.
// - transmit frame length is high byte over low byte; that many bytes sent.
// - low receive limit register holds limit bits 7:0, reset zero.
// - high receive limit register bits 5:0 are limit bits 13:8.
// - FIFO size select picks 64-byte or 16-byte threshold column.
// - frame over limit sets length error and drops data until frame start.
package ifpr_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [31:0] ADR_PRE_TRIG  = 32'h4180_001C;
  localparam logic [31:0] ADR_RX_COUNT  = 32'h4180_0028;
  localparam logic [31:0] ADR_TXLEN_LO  = 32'h4180_002C;
  localparam logic [31:0] ADR_TXLEN_HI  = 32'h4180_0030;
  localparam logic [31:0] ADR_RXMAX_LO  = 32'h4180_0034;
  localparam logic [31:0] ADR_RXMAX_HI  = 32'h4180_0038;
  localparam logic [31:0] ADR_CTRL      = 32'h4180_0040;
  localparam logic [31:0] ADR_STATUS    = 32'h4180_0044;
  localparam logic [31:0] ADR_RX_DATA   = 32'h4180_0048;

  // ****************************************************************
  // reset values and field layout
  // ****************************************************************
  localparam logic [7:0] RST_PRE_TRIG   = 8'h12;
  localparam logic [7:0] RST_ZERO8      = 8'h00;
  localparam int         PRE_LSB        = 6;
  localparam int         TRIG_LSB       = 4;
  localparam int         SFLAG_LSB      = 0;
  localparam int         RXMAX_HI_W     = 6;
  localparam int         RXMAX_W        = 14;
  localparam int         CTRL_FIR_BIT   = 6;
  localparam int         CTRL_SIZE_BIT  = 5;
  localparam int         CTRL_RXRST_BIT = 1;
  localparam int         STAT_LENERR    = 4;
  localparam int         STAT_RXEMPTY   = 0;

  // ****************************************************************
  // preamble and trigger code tables
  // ****************************************************************
  localparam logic [5:0] PRE_CODE_00 = 6'h10;
  localparam logic [5:0] PRE_CODE_01 = 6'h08;
  localparam logic [5:0] PRE_CODE_10 = 6'h04;
  localparam logic [5:0] PRE_CODE_11 = 6'h20;
  localparam logic [6:0] TRIG_16_01  = 7'h0C;
  localparam logic [6:0] TRIG_16_10  = 7'h08;
  localparam logic [6:0] TRIG_16_11  = 7'h02;
  localparam logic [6:0] TRIG_64_01  = 7'h30;
  localparam logic [6:0] TRIG_64_10  = 7'h20;
  localparam logic [6:0] TRIG_64_11  = 7'h08;

  // ****************************************************************
  // bus answers and buffering
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         RX_FIFO_DEPTH = 8;
  localparam int         RX_FIFO_WIDTH = 8;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} ifpr_tx_st_t;

endpackage

// >>> hw/ifpr_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ifpr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // clock and control
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic                       flush,
  // fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("ifpr_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      used_ff;
  logic             push;
  logic             pop;

  assign in_ready  = ce && !flush && (used_ff != (PW+1)'(DEPTH));
  assign out_valid = ce && !flush && (used_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk)
  begin
    if (ce && push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      used_ff   <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wr_ptr_ff <= '0;
        rd_ptr_ff <= '0;
        used_ff   <= '0;
      end
      else
      begin
        if (push)
          wr_ptr_ff <= wr_ptr_ff + PW'(1);
        if (pop)
          rd_ptr_ff <= rd_ptr_ff + PW'(1);
        if (push && !pop)
          used_ff <= used_ff + (PW+1)'(1);
        else if (pop && !push)
          used_ff <= used_ff - (PW+1)'(1);
      end
    end
  end

endmodule

// >>> hw/ifpr_top.sv
// frame parameter registers, receive length guard and transmit header sequencer
`timescale 1ns/100ps
module ifpr_top
#(
  parameter int FIFO_DEPTH = ifpr_pkg::RX_FIFO_DEPTH
)
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receive byte stream from line decoder
  input  wire logic        rx_bof,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_byte_ready,
  // transmit framing toward line encoder
  input  wire logic        tx_go,
  output logic             tx_sym_valid,
  output logic             tx_sym_is_data,
  input  wire logic        tx_sym_ready,
  output logic             tx_busy,
  output logic             tx_done,
  input  wire logic [6:0]  tx_fifo_free,
  output logic             tx_trigger,
  // configuration and status
  output logic             fifo_size_64,
  output logic             fir_mode,
  output logic             rx_len_error
);
  import ifpr_pkg::*;

  initial
  begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255)
      $error("ifpr_top: FIFO_DEPTH must lie in 2..255");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  pre_trig_ff;
  logic [7:0]  txlen_lo_ff;
  logic [7:0]  txlen_hi_ff;
  logic [7:0]  rxmax_lo_ff;
  logic [RXMAX_HI_W-1:0] rxmax_hi_ff;
  logic        size64_ff;
  logic        fir_ff;
  logic        rx_flush_ff;
  logic        len_err_ff;
  logic [7:0]  rx_count_ff;

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  logic        aw_held_ff;
  logic [31:0] aw_addr_ff;
  logic        w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_lane0;
  logic [31:0] nxt_rdata;
  logic        nxt_rd_ok;

  // ****************************************************************
  // datapath wires
  // ****************************************************************
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        rx_push;
  logic        rx_pop;
  logic        rx_over;
  logic        rx_drop_ff;
  logic [RXMAX_W:0] rx_frame_cnt_ff;
  logic [RXMAX_W:0] rx_cnt_base;
  logic        rx_drop_eff;
  logic [RXMAX_W-1:0] rx_limit;
  logic        len_err_set;
  logic        len_err_clr;

  ifpr_tx_st_t tx_state_ff;
  logic [15:0] tx_left_ff;
  logic [5:0]  hdr_left_ff;
  logic        tx_done_ff;
  logic        tx_trig_ff;
  logic        sym_take;
  logic [5:0]  pre_len;
  logic [6:0]  trig_lvl;

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  assign s_axi_awready = ce && !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = ce && !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_lane0      = wr_fire && w_strb_ff[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 32'h0000_0000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        case (aw_addr_ff)
          ADR_PRE_TRIG, ADR_RX_COUNT, ADR_TXLEN_LO, ADR_TXLEN_HI,
          ADR_RXMAX_LO, ADR_RXMAX_HI, ADR_CTRL, ADR_STATUS, ADR_RX_DATA:
            bresp_ff <= RESP_OKAY;
          default:
            bresp_ff <= RESP_SLVERR;
        endcase
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // writable configuration
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_trig_ff <= RST_PRE_TRIG;
      txlen_lo_ff <= RST_ZERO8;
      txlen_hi_ff <= RST_ZERO8;
      rxmax_lo_ff <= RST_ZERO8;
      rxmax_hi_ff <= RXMAX_HI_W'(RST_ZERO8);
      size64_ff   <= 1'b0;
      fir_ff      <= 1'b0;
    end
    else if (ce && wr_lane0)
    begin
      case (aw_addr_ff)
        ADR_PRE_TRIG: pre_trig_ff <= w_data_ff[7:0];
        ADR_TXLEN_LO: txlen_lo_ff <= w_data_ff[7:0];
        ADR_TXLEN_HI: txlen_hi_ff <= w_data_ff[7:0];
        // limit low byte
        // limit bits 7:0
        ADR_RXMAX_LO: rxmax_lo_ff <= w_data_ff[7:0];
        ADR_RXMAX_HI: rxmax_hi_ff <= w_data_ff[RXMAX_HI_W-1:0];
        ADR_CTRL:
        begin
          size64_ff <= w_data_ff[CTRL_SIZE_BIT];
          fir_ff    <= w_data_ff[CTRL_FIR_BIT];
        end
        default: ;
      endcase
    end
  end

  // self-clearing receive FIFO reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_flush_ff <= 1'b0;
    else if (ce)
      rx_flush_ff <= wr_lane0 && (aw_addr_ff == ADR_CTRL)
                     && w_data_ff[CTRL_RXRST_BIT];
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign s_axi_arready = ce && !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    nxt_rd_ok = 1'b1;
    case (s_axi_araddr)
      ADR_PRE_TRIG: nxt_rdata[7:0] = pre_trig_ff;
      ADR_RX_COUNT: nxt_rdata[7:0] = rx_count_ff;
      ADR_TXLEN_LO: nxt_rdata[7:0] = txlen_lo_ff;
      ADR_TXLEN_HI: nxt_rdata[7:0] = txlen_hi_ff;
      ADR_RXMAX_LO: nxt_rdata[7:0] = rxmax_lo_ff;
      ADR_RXMAX_HI: nxt_rdata[RXMAX_HI_W-1:0] = rxmax_hi_ff;
      ADR_CTRL:
      begin
        nxt_rdata[CTRL_SIZE_BIT] = size64_ff;
        nxt_rdata[CTRL_FIR_BIT]  = fir_ff;
      end
      ADR_STATUS:
      begin
        nxt_rdata[STAT_LENERR]  = len_err_ff;
        nxt_rdata[STAT_RXEMPTY] = !fifo_out_valid;
      end
      ADR_RX_DATA:
        nxt_rdata[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
      default:
        nxt_rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= nxt_rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // receive path and length guard
  // ****************************************************************
  // 14-bit limit
  assign rx_limit    = {rxmax_hi_ff, rxmax_lo_ff};
  assign rx_cnt_base = rx_bof ? '0 : rx_frame_cnt_ff;
  assign rx_drop_eff = rx_bof ? 1'b0 : rx_drop_ff;
  assign rx_over     = (rx_cnt_base + (RXMAX_W+1)'(1))
                       > {1'b0, rx_limit};
  assign rx_byte_ready = ce && (rx_drop_eff || rx_over || fifo_in_ready);
  assign rx_push     = rx_byte_valid && ce && !rx_drop_eff && !rx_over
                       && fifo_in_ready;
  assign rx_pop      = rd_fire && (s_axi_araddr == ADR_RX_DATA)
                       && fifo_out_valid;
  assign len_err_set = rx_byte_valid && ce && !rx_drop_eff && rx_over;
  assign len_err_clr = rd_fire && (s_axi_araddr == ADR_STATUS);

  ifpr_fifo
  #(
    .WIDTH (RX_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  )
  u_rx_fifo
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .flush     (rx_flush_ff),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (rx_pop),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_frame_cnt_ff <= '0;
      rx_drop_ff      <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_bof)
      begin
        rx_frame_cnt_ff <= '0;
        rx_drop_ff      <= 1'b0;
      end
      if (rx_push)
        rx_frame_cnt_ff <= rx_cnt_base + (RXMAX_W+1)'(1);
      if (len_err_set)
        rx_drop_ff <= 1'b1;
    end
  end

  // length error, set wins over clear-on-read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      len_err_ff <= 1'b0;
    else if (ce)
    begin
      if (len_err_set)
        len_err_ff <= 1'b1;
      else if (len_err_clr)
        len_err_ff <= 1'b0;
    end
  end

  // push up, read down, reset clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_count_ff <= RST_ZERO8;
    else if (ce)
    begin
      if (rx_flush_ff)
        rx_count_ff <= RST_ZERO8;
      else if (rx_push && !rx_pop)
        rx_count_ff <= rx_count_ff + 8'h01;
      else if (rx_pop && !rx_push)
        rx_count_ff <= rx_count_ff - 8'h01;
    end
  end

  // ****************************************************************
  // transmit trigger level
  // ****************************************************************
  always_comb
  begin
    trig_lvl = 7'h00;
    case (pre_trig_ff[TRIG_LSB+1:TRIG_LSB])
      2'h1:    trig_lvl = size64_ff ? TRIG_64_01 : TRIG_16_01;
      2'h2:    trig_lvl = size64_ff ? TRIG_64_10 : TRIG_16_10;
      2'h3:    trig_lvl = size64_ff ? TRIG_64_11 : TRIG_16_11;
      default: trig_lvl = 7'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_trig_ff <= 1'b0;
    else if (ce)
      tx_trig_ff <= (trig_lvl != 7'h00) && (tx_fifo_free >= trig_lvl);
  end

  // ****************************************************************
  // transmit header and length sequencer
  // ****************************************************************
  always_comb
  begin
    pre_len = PRE_CODE_00;
    case (pre_trig_ff[PRE_LSB+1:PRE_LSB])
      2'h0:    pre_len = PRE_CODE_00;
      2'h1:    pre_len = PRE_CODE_01;
      2'h2:    pre_len = PRE_CODE_10;
      2'h3:    pre_len = PRE_CODE_11;
      default: pre_len = PRE_CODE_00;
    endcase
  end

  assign sym_take = tx_sym_valid && tx_sym_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_ff <= TX_IDLE;
      tx_left_ff  <= 16'h0000;
      hdr_left_ff <= 6'h00;
      tx_done_ff  <= 1'b0;
    end
    else if (ce)
    begin
      tx_done_ff <= 1'b0;
      case (tx_state_ff)
        TX_IDLE:
          if (tx_go)
          begin
            tx_left_ff  <= {txlen_hi_ff, txlen_lo_ff};
            // relies on value of three or more
            hdr_left_ff <= fir_ff ? pre_len
                           : {2'h0, pre_trig_ff[SFLAG_LSB+3:SFLAG_LSB]};
            tx_state_ff <= TX_HDR;
          end
        TX_HDR:
          if (hdr_left_ff == 6'h00)
            tx_state_ff <= TX_DATA;
          else if (sym_take)
            hdr_left_ff <= hdr_left_ff - 6'h01;
        TX_DATA:
          if (tx_left_ff == 16'h0000)
          begin
            tx_state_ff <= TX_IDLE;
            tx_done_ff  <= 1'b1;
          end
          else if (sym_take)
            tx_left_ff <= tx_left_ff - 16'h0001;
        default:
          tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  assign tx_sym_valid   = ce && (((tx_state_ff == TX_HDR)
                                  && (hdr_left_ff != 6'h00))
                                 || ((tx_state_ff == TX_DATA)
                                  && (tx_left_ff != 16'h0000)));
  assign tx_sym_is_data = (tx_state_ff == TX_DATA);
  assign tx_busy        = (tx_state_ff != TX_IDLE);
  assign tx_done        = tx_done_ff;
  assign tx_trigger     = tx_trig_ff;
  assign fifo_size_64   = size64_ff;
  assign fir_mode       = fir_ff;
  assign rx_len_error   = len_err_ff;

endmodule

// >>> testbench/ifpr_checker.sv
// port assertions for the infrared frame parameter block
`timescale 1ns/100ps
module ifpr_checker
#(
  parameter int FIFO_DEPTH = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit framing
  input wire logic tx_go,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic tx_sym_valid,
  // status
  input wire logic rx_len_error
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ********
  // register bus
  // ********
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");

  // ********
  // transmit framing and reset
  // ********
  a_go_busy: assert property (
    tx_go && !tx_busy |=> tx_busy) else $error("frame not started");
  a_sym_framed: assert property (
    tx_sym_valid |-> tx_busy) else $error("symbol outside frame");
  a_done_pulse: assert property (
    tx_done && !tx_go |=> !tx_done && !tx_busy)
    else $error("done not a single pulse");
  a_reset_quiet: assert property (
    @(posedge aclk) disable iff (1'b0) !aresetn
    |=> !tx_busy && !s_axi_bvalid && !s_axi_rvalid && !rx_len_error)
    else $error("outputs active after reset");

  cover property (tx_done);
  cover property (rx_len_error);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind ifpr_top ifpr_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_go, .tx_busy,
  .tx_done, .tx_sym_valid, .rx_len_error);

// >>> testbench/ifpr_line_model.sv
// behavioural infrared transceiver on the line side of the block
`timescale 1ns/100ps
module ifpr_line_model
(
  // clock
  input  wire logic  aclk,
  // receive stream toward the block
  output logic       rx_bof,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  input  wire logic  rx_byte_ready,
  // transmit symbols from the block
  input  wire logic  tx_go,
  input  wire logic  tx_sym_valid,
  input  wire logic  tx_sym_is_data,
  output logic       tx_sym_ready,
  // symbol counts of the last frame
  output logic [7:0]  n_hdr,
  output logic [15:0] n_dat
);
  initial
  begin
    rx_bof = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    tx_sym_ready = 1'b0;
  end

  // acceptance stalls at random
  always @(posedge aclk)
    tx_sym_ready <= 1'($urandom);

  always @(posedge aclk)
    if (tx_go)
    begin
      n_hdr <= 8'h00;
      n_dat <= 16'h0000;
    end
    else if (tx_sym_valid && tx_sym_ready)
    begin
      if (tx_sym_is_data)
        n_dat <= n_dat + 16'h0001;
      else
        n_hdr <= n_hdr + 8'h01;
    end

  task automatic send(input int n, input logic [7:0] b0);
    int i;
    int t;
    @(posedge aclk);
    // every frame opens with its start flag
    rx_bof <= 1'b1;
    @(posedge aclk);
    rx_bof <= 1'b0;
    rx_byte_valid <= 1'b1;
    for (i = 0; i < n; i++)
    begin
      rx_byte <= b0 + 8'(i);
      t = 0;
      do
      begin
        @(posedge aclk);
        t++;
      end
      while (!rx_byte_ready && t < 400);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule

// >>> testbench/ifpr_top_bench.sv
// self-checking bench for the infrared frame parameter block
`timescale 1ns/100ps
module ifpr_top_bench;
  import ifpr_pkg::*;
  logic        aclk = 0, aresetn = 0, ce = 1, tx_go = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [6:0]  tx_fifo_free = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rx_bof, rx_byte_valid, rx_byte_ready;
  logic        tx_sym_valid, tx_sym_is_data, tx_sym_ready, tx_busy;
  logic        tx_done, tx_trigger, fifo_size_64, fir_mode, rx_len_error;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v;
  logic [7:0]  rx_byte, n_hdr;
  logic [15:0] n_dat;
  logic [33:0] q [$];
  logic [31:0] ra [5] = '{ADR_RX_COUNT, ADR_TXLEN_LO, ADR_TXLEN_HI,
                          ADR_RXMAX_LO, ADR_RXMAX_HI};
  logic [7:0]  pre [4] = '{8'h10, 8'h08, 8'h04, 8'h20};
  logic [6:0]  lv [6] = '{7'h0C, 7'h08, 7'h02, 7'h30, 7'h20, 7'h08};
  int          n_errors = 0, check_count = 0, i, s, l;

  always #2 aclk = ~aclk;

  ifpr_top dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_bof, .rx_byte_valid,
    .rx_byte, .rx_byte_ready, .tx_go, .tx_sym_valid, .tx_sym_is_data,
    .tx_sym_ready, .tx_busy, .tx_done, .tx_fifo_free, .tx_trigger,
    .fifo_size_64, .fir_mode, .rx_len_error);
  ifpr_line_model m (.aclk, .rx_bof, .rx_byte_valid, .rx_byte,
    .rx_byte_ready, .tx_go, .tx_sym_valid, .tx_sym_is_data,
    .tx_sym_ready, .n_hdr, .n_dat);

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bound(input int t);
    if (t >= 300)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end
    while (s_axi_bready && t < 300);
    bound(t);
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    int t = 0;
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end
    while (s_axi_rready && t < 300);
    bound(t);
  endtask

  // ********
  // result watcher
  // ********
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (tx_done)
      cmp({10'h0, n_hdr, n_dat}, q.pop_front());
  end

  // ********
  // main sequence
  // ********
  initial
  begin
    void'($urandom(52387));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADR_PRE_TRIG, 34'h12);
    for (i = 0; i < 5; i++)
      rd(ra[i], 34'h0);
    rd(32'h4180_0020, {RESP_SLVERR, 32'h0});
    for (i = 1; i < 5; i++)
    begin
      v = $urandom;
      wr(ra[i], v);
      rd(ra[i], {26'h0, v[7:0] & (i == 4 ? 8'h3F : 8'hFF)});
    end
    wr(ADR_RXMAX_HI, 32'h0);
    wr(ADR_RXMAX_LO, 32'h3);
    m.send(3, 8'hA0);
    repeat (2) @(posedge aclk);
    rd(ADR_RX_COUNT, 34'h3);
    for (i = 0; i < 3; i++)
      rd(ADR_RX_DATA, 34'hA0 + 34'(i));
    m.send(5, 8'hB0);
    repeat (2) @(posedge aclk);
    rd(ADR_RX_COUNT, 34'h3);
    cmp({33'h0, rx_len_error}, 34'h1);
    rd(ADR_STATUS, 34'h10);
    rd(ADR_STATUS, 34'h0);
    wr(ADR_CTRL, 32'h2);
    rd(ADR_RX_COUNT, 34'h0);
    wr(ADR_RXMAX_LO, 32'h40);
    fork
      m.send(10, 8'hC0);
    join_none
    repeat (40) @(posedge aclk);
    rd(ADR_RX_COUNT, 34'h8);
    for (i = 0; i < 10; i++)
      rd(ADR_RX_DATA, 34'hC0 + 34'(i));
    wr(ADR_TXLEN_HI, 32'h0);
    for (i = 0; i < 5; i++)
    begin
      s = 3 + $urandom % 13;
      l = 1 + $urandom % 4;
      wr(ADR_TXLEN_LO, l);
      wr(ADR_PRE_TRIG, {24'h0, 2'(i), 2'h1, 4'(s)});
      wr(ADR_CTRL, {25'h0, i < 4, 6'h0});
      cmp({33'h0, fir_mode}, {33'h0, i < 4});
      q.push_back({10'h0, i < 4 ? pre[i % 4] : 8'(s), 16'(l)});
      tx_go <= 1'b1;
      @(posedge aclk);
      tx_go <= 1'b0;
      s = 0;
      do
      begin
        @(posedge aclk);
        s++;
      end
      while (!tx_done && s < 300);
      bound(s);
    end
    for (i = 0; i < 6; i++)
    begin
      wr(ADR_CTRL, {26'h0, i > 2, 5'h0});
      wr(ADR_PRE_TRIG, {26'h0, 2'(i % 3 + 1), 4'h3});
      tx_fifo_free <= lv[i] - 7'h1;
      repeat (3) @(posedge aclk);
      cmp({33'h0, tx_trigger}, 34'h0);
      tx_fifo_free <= lv[i];
      repeat (3) @(posedge aclk);
      cmp({32'h0, fifo_size_64, tx_trigger}, {32'h0, i > 2, 1'b1});
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADR_TXLEN_LO, 34'h0);
    rd(ADR_PRE_TRIG, 34'h12);
    wrap_up();
  end
endmodule
